/* verilog/flash_regs.svh */
// constants shared by the serial flash device end and the host controller
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// opcodes
`define OP_WRITE_UNLOCK          8'h06
`define OP_STATUS_READ           8'h05
`define OP_SMALLEST_UNIT_CLEAR   8'h20
`define OP_BLOCK_CLEAR_32K       8'h52
`define OP_BLOCK_CLEAR_64K       8'hd8
`define OP_ARRAY_CLEAR_A         8'h60
`define OP_ARRAY_CLEAR_B         8'hc7
`define OP_MAKER_DEVICE_ID_READ  8'h90
`define OP_STANDARD_ID_READ      8'h9f
`define OP_UNIQUE_ID_READ        8'h4b
`define OP_SECURITY_CLEAR        8'h44

// bit counts at which a frame is complete, and the count where it saturates
`define BITS_OPCODE              8'h08
`define BITS_ADDRESSED           8'h20
`define BITS_UID_LEAD            8'h28
`define BITS_SATURATE            8'hff

// erase region masks and protection geometry
`define SECTOR_MASK              24'h000fff
`define BLK32_MASK               24'h007fff
`define BLK64_MASK               24'h00ffff
`define SECREG_MASK              24'h0003ff
`define PROT_UNIT_SMALL          25'h0001000
`define PROT_UNIT_LARGE          25'h0010000
`define ARRAY_TOP                25'h1000000

// self-timed cycle durations in microseconds, and in clock cycles
`define CLK_MHZ                  100
`define T_SE_US                  100
`define T_BE1_US                 200
`define T_BE2_US                 300
`define T_CE_US                  400
`define SE_CYCLES                (`T_SE_US * `CLK_MHZ)
`define BE1_CYCLES               (`T_BE1_US * `CLK_MHZ)
`define BE2_CYCLES               (`T_BE2_US * `CLK_MHZ)
`define CE_CYCLES                (`T_CE_US * `CLK_MHZ)

// host register word indices (byte address = 4 * index)
`define REG_CMD                  3'h0
`define REG_ADDR                 3'h1
`define REG_STATUS               3'h2
`define REG_RX0                  3'h4
`define CMD_ADDR_BIT             8
`define CMD_DUMMY_BIT            9
`define CMD_RXLEN_LSB            16
`define RXLEN_MAX                5'h10
`define SCLK_HALF                4'h8

`endif

/* verilog/flash_pkg.sv */
// types shared by the serial flash device end and the host controller
package flash_pkg;
   typedef enum logic [2:0] {
      EK_NONE   = 3'b000,
      EK_SECTOR = 3'b001,
      EK_BLK32  = 3'b010,
      EK_BLK64  = 3'b011,
      EK_CHIP   = 3'b100,
      EK_SECREG = 3'b101
   } erase_kind_t;

   typedef enum logic [1:0] {
      HS_IDLE  = 2'b00,
      HS_SETUP = 2'b01,
      HS_SHIFT = 2'b10,
      HS_GAP   = 2'b11
   } host_state_t;
endpackage

/* verilog/spi_flash_if.sv */
// serial flash link between the host controller and the device end
interface spi_flash_if;
   logic cs_n;    // chip select, active low
   logic sclk;    // serial clock from the host
   logic si;      // serial data into the device
   logic so;      // serial data out of the device
   logic so_oe;   // device drives so
   logic so_line; // resolved output wire, pulled high when undriven

   assign so_line = so_oe ? so : 1'b1;

   modport host   (output cs_n, output sclk, output si, input so_line);
   modport device (input cs_n, input sclk, input si, output so,
                   output so_oe);
endinterface

/* verilog/flash_device.sv */
// device end: erase, write unlock, status and identification commands
// Operation
// - sector clear: 20h plus three address bytes
// - 32KB block clear: 52h plus address
// - 64KB block clear: d8h plus address
// - array clear: 60h or c7h alone
// - addressed clear only if deselect after 32 bits
// - array clear only if deselect after 8 bits
// - every clear needs write enable latch set
// - accepted clear sets busy flag until done
// - latch cleared before the cycle ends
// - status read still answered while busy
// - protected sectors or blocks are never cleared; array clear at low field 7 with complement set still erases protected ones
// - array clear only with all-zero/all-one protect match
// - each clear type has its own duration, except security clear, which uses the sector one
// - 90h, zero address, then maker and device codes
// - 9fh returns maker, type, capacity bytes
// - 9fh ignored while a cycle runs
// - host avoids 9fh in deep power-down
// - deselect ends identification output at once
// - 4bh, address, dummy, then 128-bit serial
// - three security registers selected by address 15:12
// - locked security registers ignore clear commands
// - opcode and address sampled on rising clock
`include "flash_regs.svh"
module flash_device
   import flash_pkg::*;
#(
   parameter int unsigned  SE_CYCLES    = `SE_CYCLES,
   parameter int unsigned  BE1_CYCLES   = `BE1_CYCLES,
   parameter int unsigned  BE2_CYCLES   = `BE2_CYCLES,
   parameter int unsigned  CE_CYCLES    = `CE_CYCLES,
   parameter logic [7:0]   MAKER_CODE   = 8'h5a, // arbitrary value
   parameter logic [7:0]   DEVICE_CODE  = 8'h17, // arbitrary value
   parameter logic [7:0]   MEM_TYPE     = 8'h40, // arbitrary value
   parameter logic [7:0]   CAPACITY     = 8'h18, // arbitrary value
   parameter logic [127:0] UNIQUE_ID    =
      128'h0123456789abcdeffedcba9876543210      // arbitrary value
)(
   input  wire logic       ref_clk,            // 100 MHz clock
   input  wire logic       reset_n,            // synchronous reset
   spi_flash_if.device     link,               // serial link pins
   input  wire logic [4:0] block_protect_bits, // protect field
   input  wire logic       protect_complement, // invert protection
   input  wire logic [2:0] security_lock_bits, // per-register locks
   output logic            write_in_progress,  // busy flag
   output logic            write_enable_latch, // write unlock state
   output erase_kind_t     erase_kind,         // running or last kind
   output logic [23:0]     erase_addr          // base of region
);
   logic [2:0]   sync1_q;
   logic [2:0]   sync2_q;
   logic         cs_prev_q;
   logic         sclk_prev_q;
   logic [31:0]  in_sr_q;
   logic [7:0]   bit_cnt_q;
   logic [7:0]   op_q;
   logic [127:0] out_sr_q;
   logic         out_act_q;
   logic         so_q;
   logic         wip_q;
   logic         wel_q;
   logic [31:0]  ecnt_q;
   erase_kind_t  kind_q;
   logic [23:0]  eaddr_q;

   // pins come from another domain: two flops before any use
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sync1_q <= 3'h4;
         sync2_q <= 3'h4;
      end else begin
         sync1_q <= {link.cs_n, link.sclk, link.si};
         sync2_q <= sync1_q;
      end
   end

   wire cs_n_s = sync2_q[2];
   wire sclk_s = sync2_q[1];
   wire si_s   = sync2_q[0];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_prev_q   <= cs_n_s;
         sclk_prev_q <= sclk_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
   wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
   wire cs_rise   = cs_n_s & ~cs_prev_q;
   wire cs_fall   = ~cs_n_s & cs_prev_q;

   // input shifter and saturating bit count
   wire [7:0]  cnt_next = (bit_cnt_q == `BITS_SATURATE) ? bit_cnt_q
                          : bit_cnt_q + 8'h01;
   wire [31:0] in_next  = {in_sr_q[30:0], si_s};
   wire [7:0]  op_new   = in_next[7:0];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         in_sr_q   <= 32'h0;
         bit_cnt_q <= 8'h00;
         op_q      <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt_q <= 8'h00;
      end else if (sclk_rise) begin
         in_sr_q   <= in_next;
         bit_cnt_q <= cnt_next;
         if (cnt_next == `BITS_OPCODE)
            op_q <= op_new;
      end
   end

   // output loads; a busy device decodes nothing but status reads
   wire [7:0]   status_byte = {6'h00, wel_q, wip_q};
   wire at_op   = sclk_rise & (cnt_next == `BITS_OPCODE);
   wire ld_sts  = at_op & (op_new == `OP_STATUS_READ);
   wire ld_std  = at_op & ~wip_q
                  & (op_new == `OP_STANDARD_ID_READ);
   wire ld_mdid = sclk_rise & ~wip_q & (cnt_next == `BITS_ADDRESSED)
                  & (op_q == `OP_MAKER_DEVICE_ID_READ);
   wire ld_uid  = sclk_rise & ~wip_q & (cnt_next == `BITS_UID_LEAD)
                  & (op_q == `OP_UNIQUE_ID_READ);
   wire ld_any  = ld_sts | ld_std | ld_mdid | ld_uid;
   wire [127:0] ld_val =
      ld_sts  ? {16{status_byte}} :
      ld_std  ? {MAKER_CODE, MEM_TYPE, CAPACITY, 104'h0} :
      ld_mdid ? {MAKER_CODE, DEVICE_CODE, 112'h0} :
      UNIQUE_ID;

   // bits leave msb first, each on a falling serial clock edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         out_sr_q  <= 128'h0;
         out_act_q <= 1'b0;
         so_q      <= 1'b0;
      end else if (cs_n_s) begin
         out_act_q <= 1'b0;
      end else if (ld_any) begin
         out_sr_q  <= ld_val;
         out_act_q <= 1'b1;
      end else if (sclk_fall & out_act_q) begin
         so_q      <= out_sr_q[127];
         out_sr_q  <= {out_sr_q[126:0], 1'b0};
      end
   end

   // region of the addressed command
   wire [23:0] addr_in  = in_sr_q[23:0];
   wire [23:0] mask     =
      (op_q == `OP_SMALLEST_UNIT_CLEAR) ? `SECTOR_MASK :
      (op_q == `OP_BLOCK_CLEAR_32K)     ? `BLK32_MASK  : `BLK64_MASK;
   wire [23:0] reg_lo   = addr_in & ~mask;
   wire [23:0] reg_hi   = addr_in | mask;

   // protected range: top or bottom share, sized by the low field
   wire [2:0]  bp_lo    = block_protect_bits[2:0];
   wire [24:0] unit     = block_protect_bits[4] ? `PROT_UNIT_SMALL
                          : `PROT_UNIT_LARGE;
   wire [24:0] psize    = (bp_lo == 3'h0) ? 25'h0
                          : unit << (bp_lo - 3'h1);
   wire [24:0] plim     = `ARRAY_TOP - psize;
   wire        bottom   = block_protect_bits[3];
   wire        hit_top  = protect_complement ? ({1'b0, reg_lo} < plim)
                          : ({1'b0, reg_hi} >= plim);
   wire        hit_bot  = protect_complement ? ({1'b0, reg_hi} >= psize)
                          : ({1'b0, reg_lo} < psize);
   wire        prot_hit = bottom ? hit_bot : hit_top;
   wire        chip_ok  = ((bp_lo == 3'h0) & ~protect_complement)
                          | ((bp_lo == 3'h7) & protect_complement);

   // security register address check and per-register lock
   wire [3:0]  sec_idx  = addr_in[15:12];
   wire [2:0]  sec_sel  = (sec_idx == 4'h1) ? 3'h1 :
                          (sec_idx == 4'h2) ? 3'h2 :
                          (sec_idx == 4'h3) ? 3'h4 : 3'h0;
   wire        sec_ok   = (addr_in[23:16] == 8'h00)
                          & (addr_in[11:10] == 2'h0)
                          & (sec_sel != 3'h0);
   wire        sec_lock = |(sec_sel & security_lock_bits);

   // accepted only on deselect at an exact bit count
   wire frame8  = bit_cnt_q == `BITS_OPCODE;
   wire frame32 = bit_cnt_q == `BITS_ADDRESSED;
   wire may_go  = cs_rise & ~wip_q & wel_q;
   wire is_area = (op_q == `OP_SMALLEST_UNIT_CLEAR)
                  | (op_q == `OP_BLOCK_CLEAR_32K)
                  | (op_q == `OP_BLOCK_CLEAR_64K);
   wire is_chip = (op_q == `OP_ARRAY_CLEAR_A)
                  | (op_q == `OP_ARRAY_CLEAR_B);
   wire go_area = may_go & frame32 & is_area & ~prot_hit;
   wire go_chip = may_go & frame8 & is_chip & chip_ok;
   wire go_sec  = may_go & frame32 & (op_q == `OP_SECURITY_CLEAR)
                  & sec_ok & ~sec_lock;
   wire go      = go_area | go_chip | go_sec;
   wire unlock  = cs_rise & ~wip_q & frame8
                  & (op_q == `OP_WRITE_UNLOCK);

   wire erase_kind_t kind_new =
      go_chip ? EK_CHIP :
      go_sec  ? EK_SECREG :
      (op_q == `OP_SMALLEST_UNIT_CLEAR) ? EK_SECTOR :
      (op_q == `OP_BLOCK_CLEAR_32K)     ? EK_BLK32 : EK_BLK64;
   wire [31:0] dur_new =
      go_chip ? CE_CYCLES :
      go_sec  ? SE_CYCLES :
      (op_q == `OP_SMALLEST_UNIT_CLEAR) ? SE_CYCLES :
      (op_q == `OP_BLOCK_CLEAR_32K)     ? BE1_CYCLES : BE2_CYCLES;
   wire [23:0] base_new =
      go_chip ? 24'h000000 :
      go_sec  ? (addr_in & ~`SECREG_MASK) : reg_lo;

   // self-timed cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wip_q   <= 1'b0;
         ecnt_q  <= 32'h0;
         kind_q  <= EK_NONE;
         eaddr_q <= 24'h000000;
      end else if (go) begin
         wip_q   <= 1'b1;
         ecnt_q  <= dur_new - 32'h1;
         kind_q  <= kind_new;
         eaddr_q <= base_new;
      end else if (wip_q) begin
         if (ecnt_q == 32'h0)
            wip_q  <= 1'b0;
         else
            ecnt_q <= ecnt_q - 32'h1;
      end
   end

   // latch drops as the cycle starts, well before it finishes
   always_ff @(posedge ref_clk) begin
      if (!reset_n)
         wel_q <= 1'b0;
      else if (go)
         wel_q <= 1'b0;
      else if (unlock)
         wel_q <= 1'b1;
   end

   assign link.so            = so_q;
   assign link.so_oe         = out_act_q;
   assign write_in_progress  = wip_q;
   assign write_enable_latch = wel_q;
   assign erase_kind         = kind_q;
   assign erase_addr         = eaddr_q;
endmodule

/* verilog/flash_host.sv */
// host end: avalon-mm command registers driving the serial flash link
`include "flash_regs.svh"
module flash_host
   import flash_pkg::*;
(
   input  wire logic        ref_clk,         // 100 MHz clock
   input  wire logic        reset_n,         // synchronous reset
   input  wire logic [2:0]  avs_address,     // word index
   input  wire logic        avs_read,        // read request
   input  wire logic        avs_write,       // write request
   input  wire logic [31:0] avs_writedata,   // write data
   output logic [31:0]      avs_readdata,    // read data
   output logic             avs_waitrequest, // stall
   spi_flash_if.host        link             // serial link pins
);
   host_state_t state_q;
   logic [31:0] cmd_q;
   logic [23:0] addr_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic [3:0]  div_q;
   logic        cs_q;
   logic        sclk_q;
   logic        si_q;
   logic [39:0] tx_sr_q;
   logic [7:0]  bit_q;
   logic [7:0]  rx_sr_q;
   logic        so1_q;
   logic        so2_q;
   logic [7:0]  rx_mem [0:15];

   wire req    = avs_read | avs_write;
   wire accept = req & ~wait_q;
   wire busy   = state_q != HS_IDLE;
   wire start  = accept & avs_write & (avs_address == `REG_CMD) & ~busy;
   wire tick   = div_q == (`SCLK_HALF - 4'h1);

   // frame length from the command word
   wire [4:0] rxlen_raw = avs_writedata[`CMD_RXLEN_LSB +: 5];
   wire [4:0] rxlen_c   = cmd_q[`CMD_RXLEN_LSB +: 5];
   wire [4:0] rxlen     = (rxlen_c > `RXLEN_MAX) ? `RXLEN_MAX : rxlen_c;
   wire [7:0] tx_bits   = `BITS_OPCODE
                          + (cmd_q[`CMD_ADDR_BIT] ? 8'h18 : 8'h00)
                          + (cmd_q[`CMD_DUMMY_BIT] ? 8'h08 : 8'h00);
   wire [7:0] tot_bits  = tx_bits + {rxlen, 3'h0};
   wire [7:0] rx_pos    = bit_q - tx_bits;
   wire       rx_phase  = bit_q >= tx_bits;
   wire [7:0] rx_byte   = {rx_sr_q[6:0], so2_q};

   // half-period enable for the serial clock
   always_ff @(posedge ref_clk) begin
      if (!reset_n || start || tick)
         div_q <= 4'h0;
      else
         div_q <= div_q + 4'h1;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         so1_q <= 1'b1;
         so2_q <= 1'b1;
      end else begin
         so1_q <= link.so_line;
         so2_q <= so1_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wait_q <= 1'b1;
         addr_q <= 24'h000000;
      end else begin
         wait_q <= ~(req & wait_q);
         if (accept & avs_write & (avs_address == `REG_ADDR))
            addr_q <= avs_writedata[23:0];
      end
   end

   // read data settles one cycle ahead of the accepting edge
   wire [1:0]  rxw     = avs_address[1:0];
   wire [31:0] rx_word = {rx_mem[{rxw, 2'h3}], rx_mem[{rxw, 2'h2}],
                          rx_mem[{rxw, 2'h1}], rx_mem[{rxw, 2'h0}]};
   wire [31:0] rd_mux =
      (avs_address == `REG_CMD)    ? cmd_q :
      (avs_address == `REG_ADDR)   ? {8'h00, addr_q} :
      (avs_address == `REG_STATUS) ? {31'h0, busy} :
      avs_address[2]               ? rx_word : 32'h0;

   always_ff @(posedge ref_clk) begin
      if (!reset_n)
         rdata_q <= 32'h0;
      else if (avs_read & wait_q)
         rdata_q <= rd_mux;
   end

   // frame sequencer; data changes only while the serial clock is low
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_q <= HS_IDLE;
         cmd_q   <= 32'h0;
         cs_q    <= 1'b1;
         sclk_q  <= 1'b0;
         si_q    <= 1'b0;
         tx_sr_q <= 40'h0;
         bit_q   <= 8'h00;
         rx_sr_q <= 8'h00;
      end else begin
         case (state_q)
            HS_IDLE: begin
               if (start) begin
                  cmd_q   <= {avs_writedata[31:21],
                              (rxlen_raw > `RXLEN_MAX) ? `RXLEN_MAX
                                                       : rxlen_raw,
                              avs_writedata[15:0]};
                  tx_sr_q <= avs_writedata[`CMD_ADDR_BIT]
                             ? {avs_writedata[7:0], addr_q, 8'h00}
                             : {avs_writedata[7:0], 32'h0};
                  cs_q    <= 1'b0;
                  bit_q   <= 8'h00;
                  state_q <= HS_SETUP;
               end
            end
            HS_SETUP: begin
               if (tick) begin
                  si_q    <= tx_sr_q[39];
                  state_q <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (tick && !sclk_q) begin
                  sclk_q <= 1'b1;
               end else if (tick) begin
                  sclk_q  <= 1'b0;
                  bit_q   <= bit_q + 8'h01;
                  tx_sr_q <= {tx_sr_q[38:0], 1'b0};
                  si_q    <= tx_sr_q[38];
                  if (rx_phase)
                     rx_sr_q <= rx_byte;
                  if (bit_q + 8'h01 == tot_bits)
                     state_q <= HS_GAP;
               end
            end
            HS_GAP: begin
               if (tick && !cs_q)
                  cs_q <= 1'b1;
               else if (tick)
                  state_q <= HS_IDLE;
            end
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   // received bytes land in order, byte 0 in the low lane of rx word 0
   always_ff @(posedge ref_clk) begin
      if (state_q == HS_SHIFT && tick && sclk_q && rx_phase
          && rx_pos[2:0] == 3'h7)
         rx_mem[rx_pos[6:3]] <= rx_byte;
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign link.cs_n       = cs_q;
   assign link.sclk       = sclk_q;
   assign link.si         = si_q;
endmodule

/* testbench/flash_link_asserts.sv */
// erase timing and serial output checks for the flash link
module flash_link_asserts
   import flash_pkg::*;
#(
   parameter int unsigned SE_CYCLES  = 1,
   parameter int unsigned BE1_CYCLES = 1,
   parameter int unsigned BE2_CYCLES = 1,
   parameter int unsigned CE_CYCLES  = 1
)(
   input wire logic  ref_clk,            // clock
   input wire logic  reset_n,            // sync reset
   input wire logic  cs_n,               // select
   input wire logic  sclk,               // serial clock
   input wire logic  so,                 // device data
   input wire logic  so_oe,              // device drives so
   input wire logic  write_in_progress,  // busy flag
   input wire logic  write_enable_latch, // unlock state
   input erase_kind_t erase_kind         // running kind
);
   logic [15:0] busy_q;

   // counts busy cycles so long erase times need no long repetition
   always_ff @(posedge ref_clk) begin
      if (!reset_n)
         busy_q <= 16'h0;
      else
         busy_q <= write_in_progress ? busy_q + 16'h1 : 16'h0;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence start_s;
      $rose(write_in_progress);
   endsequence
   sequence desel_s;
      cs_n [*6];
   endsequence
   property len_p(erase_kind_t k, int n);
      $fell(write_in_progress) && erase_kind == k |-> busy_q == n;
   endproperty

   a_sector_time: assert property (len_p(EK_SECTOR, SE_CYCLES))
      else $error("sector erase length wrong");
   a_secreg_time: assert property (len_p(EK_SECREG, SE_CYCLES))
      else $error("security erase length wrong");
   a_blk32_time: assert property (len_p(EK_BLK32, BE1_CYCLES))
      else $error("32k erase length wrong");
   a_blk64_time: assert property (len_p(EK_BLK64, BE2_CYCLES))
      else $error("64k erase length wrong");
   a_chip_time: assert property (len_p(EK_CHIP, CE_CYCLES))
      else $error("array erase length wrong");
   a_wel_cleared: assert property (start_s |-> ##[0:3] !write_enable_latch)
      else $error("latch not cleared");
   a_wel_needed: assert property (start_s |-> $past(write_enable_latch, 3))
      else $error("erase without latch");
   a_start_desel: assert property (start_s |-> cs_n && $past(cs_n))
      else $error("erase started while selected");
   a_idle_quiet: assert property (desel_s |-> !so_oe)
      else $error("output driven while deselected");
   a_so_on_low: assert property (
      so_oe && $past(so_oe) && $changed(so) |-> !sclk)
      else $error("output changed with clock high");
   a_kind_held: assert property (
      write_in_progress && $past(write_in_progress) |-> $stable(erase_kind))
      else $error("running erase disturbed");
endmodule

/* testbench/serial_flash_erase_and_id_test.sv */
// bench: host and device ends joined over the serial link
module serial_flash_erase_and_id_test
   import flash_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // id values below are arbitrary
   localparam logic [7:0]   MK  = 8'h3c;
   localparam logic [7:0]   DV  = 8'h21;
   localparam logic [7:0]   MT  = 8'h62;
   localparam logic [7:0]   CP  = 8'h15;
   localparam logic [127:0] UID = 128'hfeed0123cafe4567beef89abdead0cdf;
   // erase times long enough to fit two frames inside the shortest one
   localparam int unsigned  T_SE  = 1000;
   localparam int unsigned  T_BE1 = 1200;
   localparam int unsigned  T_BE2 = 1400;
   localparam int unsigned  T_CE  = 1600;
   logic        ref_clk            = 1'b0;
   logic        reset_n            = 1'b0;
   logic [2:0]  avs_address        = 3'h0;
   logic        avs_read           = 1'b0;
   logic        avs_write          = 1'b0;
   logic [31:0] avs_writedata      = 32'h0;
   logic [4:0]  block_protect_bits = 5'h0;
   logic        protect_complement = 1'b0;
   logic [2:0]  security_lock_bits = 3'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        write_in_progress;
   logic        write_enable_latch;
   erase_kind_t erase_kind;
   logic [23:0] erase_addr;
   logic [31:0] rx;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   spi_flash_if link ();
   flash_host flash_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .link(link));
   flash_device #(.SE_CYCLES(T_SE), .BE1_CYCLES(T_BE1), .BE2_CYCLES(T_BE2),
      .CE_CYCLES(T_CE), .MAKER_CODE(MK), .DEVICE_CODE(DV),
      .MEM_TYPE(MT), .CAPACITY(CP), .UNIQUE_ID(UID)) flash_device_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .link(link),
      .block_protect_bits(block_protect_bits),
      .protect_complement(protect_complement),
      .security_lock_bits(security_lock_bits),
      .write_in_progress(write_in_progress),
      .write_enable_latch(write_enable_latch),
      .erase_kind(erase_kind), .erase_addr(erase_addr));
   flash_link_asserts #(.SE_CYCLES(T_SE), .BE1_CYCLES(T_BE1),
      .BE2_CYCLES(T_BE2), .CE_CYCLES(T_CE)) flash_link_asserts_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(link.cs_n),
      .sclk(link.sclk), .so(link.so), .so_oe(link.so_oe),
      .write_in_progress(write_in_progress),
      .write_enable_latch(write_enable_latch), .erase_kind(erase_kind));

   always #5 ref_clk = ~ref_clk;

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         test_done;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask

   // outputs are flops, so the value seen just after the edge is the sample
   task automatic bus(input logic rd, input logic [2:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      avs_read      <= rd;
      avs_write     <= !rd;
      avs_address   <= a;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rx = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic run(input logic [31:0] cmd, input logic [23:0] a);
      bus(1'b0, 3'h1, {8'h0, a});
      bus(1'b0, 3'h0, cmd);
      rx = 32'h1;
      for (int i = 0; i < 2000 && rx[0] !== 1'b0; i++)
         bus(1'b1, 3'h2, 32'h0);
   endtask

   // pr packs protect bits, complement and lock bits
   task automatic er(input logic [7:0] op, input logic [23:0] a,
                     input logic ad, input logic ul, input logic [8:0] pr,
                     input erase_kind_t k, input logic [23:0] base);
      @(posedge ref_clk);
      {block_protect_bits, protect_complement, security_lock_bits} <= pr;
      if (ul)
         run(32'h6, 24'h0);
      run({23'h0, ad, op}, a);
      for (int i = 0; i < 40 && write_in_progress !== 1'b1; i++)
         @(posedge ref_clk);
      if (k == EK_NONE) begin
         chk("refused_busy", 32'h0, {31'h0, write_in_progress});
      end else begin
         chk("kind", {29'h0, k}, {29'h0, erase_kind});
         chk("base", {8'h0, base}, {8'h0, erase_addr});
         run(32'h10005, 24'h0);
         bus(1'b1, 3'h4, 32'h0);
         chk("status_busy", 32'h1, {24'h0, rx[7:0]});
         run(32'h1009f, 24'h0);
         bus(1'b1, 3'h4, 32'h0);
         chk("id_in_erase", 32'hff, {24'h0, rx[7:0]});
         for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++)
            @(posedge ref_clk);
         chk("done_busy", 32'h0, {31'h0, write_in_progress});
      end
   endtask

   initial begin
      logic [31:0] e;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      run(32'h1009f, 24'h0);
      bus(1'b1, 3'h4, 32'h0);
      chk("id_cut", {24'h0, MK}, {24'h0, rx[7:0]});
      run(32'h3009f, 24'h0);
      bus(1'b1, 3'h4, 32'h0);
      chk("std_id", {8'h0, CP, MT, MK}, {8'h0, rx[23:0]});
      run(32'h20190, 24'h0);
      bus(1'b1, 3'h4, 32'h0);
      chk("maker_dev", {16'h0, DV, MK}, {16'h0, rx[15:0]});
      run(32'h10034b, 24'h0);
      for (int w = 0; w < 4; w++) begin
         bus(1'b1, 3'(4 + w), 32'h0);
         for (int b = 0; b < 4; b++)
            e[8*b +: 8] = UID[127 - 8*(4*w + b) -: 8];
         chk("unique_id", e, rx);
      end
      er(8'h20, 24'h123456, 1, 1, 9'h0, EK_SECTOR, 24'h123000);
      er(8'h52, 24'h12abcd, 1, 1, 9'h0, EK_BLK32, 24'h128000);
      er(8'hd8, 24'h12abcd, 1, 1, 9'h0, EK_BLK64, 24'h120000);
      er(8'h60, 24'h0, 0, 1, 9'h0, EK_CHIP, 24'h0);
      er(8'hc7, 24'h0, 0, 1, 9'h078, EK_CHIP, 24'h0);
      er(8'h44, 24'h002155, 1, 1, 9'h0, EK_SECREG, 24'h002000);
      er(8'h20, 24'h123456, 1, 0, 9'h0, EK_NONE, 24'h0);
      er(8'h20, 24'h123456, 0, 1, 9'h0, EK_NONE, 24'h0);
      er(8'h60, 24'h0, 1, 1, 9'h0, EK_NONE, 24'h0);
      er(8'h60, 24'h0, 0, 1, 9'h010, EK_NONE, 24'h0);
      er(8'h20, 24'hff0123, 1, 1, 9'h010, EK_NONE, 24'h0);
      er(8'h20, 24'h0f0123, 1, 1, 9'h010, EK_SECTOR, 24'h0f0000);
      er(8'h44, 24'h002000, 1, 1, 9'h002, EK_NONE, 24'h0);
      er(8'h44, 24'h004000, 1, 1, 9'h0, EK_NONE, 24'h0);
      test_done;
   end
endmodule
